// ### fpet_pkg.sv
// constants for the flash program and erase timing sequencer
package fpet_pkg;

	// ****************************************************************
	// clock and rate figures
	// ****************************************************************
	localparam int CLK_KHZ         = 100000;
	localparam int BUS_MIN_KHZ     = 1000;
	localparam int OP_MIN_KHZ      = 150;
	localparam int OP_MAX_KHZ      = 200;
	// shortest and longest operation clock period in bus cycles
	localparam int OP_PER_MIN_CYC  = (CLK_KHZ + OP_MAX_KHZ - 1) / OP_MAX_KHZ;
	localparam int OP_PER_MAX_CYC  = CLK_KHZ / OP_MIN_KHZ;

	// ****************************************************************
	// operation timing counts
	// ****************************************************************
	localparam int SWP_BUS         = 25;
	localparam int SWP_TICKS       = 9;
	localparam int BWP_BUS         = 9;
	localparam int BWP_TICKS       = 4;
	localparam int BURST_WORDS     = 64;
	localparam int ERASE_PULSES    = 16;
	localparam int ERASE_TICKS     = 4000;
	localparam int ERASE_PULSE_TK  = ERASE_TICKS / ERASE_PULSES;
	localparam int MASS_TICKS      = 20000;
	localparam int SCAN_SETUP      = 10;
	localparam int SCAN_WORDS      = 65536;
	localparam int SCAN_MIN_CYC    = 11;
	localparam int SCAN_MAX_CYC    = 65546;

	// ****************************************************************
	// widths
	// ****************************************************************
	localparam int DIV_W           = 9;
	localparam int TICK_W          = 16;
	localparam int ADDR_W          = 16;

	// ****************************************************************
	// commands and states
	// ****************************************************************
	typedef enum logic [2:0] {
		OP_NONE  = 3'h0,
		OP_PROG  = 3'h1,
		OP_BURST = 3'h2,
		OP_SECT  = 3'h3,
		OP_MASS  = 3'h4,
		OP_BLANK = 3'h5
	} fpet_op_e;

	typedef enum logic [1:0] {
		ST_IDLE  = 2'h0,
		ST_SETUP = 2'h1,
		ST_OPCLK = 2'h2,
		ST_SCAN  = 2'h3
	} fpet_state_e;

endpackage

// ### fpet_seq.sv
// flash program, erase and blank check timing sequencer
module fpet_seq
	import fpet_pkg::*;
#(
	parameter int ERASE_PULSE_TICKS = ERASE_PULSE_TK,
	parameter int MASS_OP_TICKS     = MASS_TICKS,
	parameter int SCAN_WORD_COUNT   = SCAN_WORDS
) (
	input  wire logic              i_clk,
	input  wire logic              i_rst_n,
	input  wire logic              i_cmd_valid,
	input  wire logic [2:0]        i_cmd_op,
	input  wire logic [DIV_W-1:0]  i_flash_clock_divider,
	input  wire logic              i_burst_more,
	input  wire logic              i_word_blank,
	output logic                   o_busy,
	output logic                   o_cmd_done,
	output logic                   o_word_done,
	output logic                   o_prog_pulse,
	output logic                   o_erase_pulse,
	output logic [ADDR_W-1:0]      o_scan_addr,
	output logic                   o_scan_fail
);

	// ****************************************************************
	// helpers
	// ****************************************************************
	function automatic logic is_prog(input logic [2:0] op);
		is_prog = (op == OP_PROG) || (op == OP_BURST);
	endfunction

	function automatic logic is_erase(input logic [2:0] op);
		is_erase = (op == OP_SECT) || (op == OP_MASS);
	endfunction

	// ****************************************************************
	// sequencer state
	// ****************************************************************
	fpet_state_e       state_r, state_nxt;
	logic [2:0]        op_r, op_nxt;
	logic [DIV_W-1:0]  div_r, div_nxt;
	logic [DIV_W-1:0]  dcnt_r, dcnt_nxt;
	logic [TICK_W-1:0] tick_r, tick_nxt;
	logic [4:0]        bus_r, bus_nxt;
	logic [4:0]        pulse_r, pulse_nxt;
	logic [5:0]        word_r, word_nxt;
	logic [ADDR_W-1:0] addr_r, addr_nxt;
	logic              fail_r, fail_nxt;
	logic              done_r, done_nxt;
	logic              wdone_r, wdone_nxt;
	logic              busy_r, prog_r, erase_r;
	logic [31:0]       cyc_r, cyc_nxt;
	logic              fin;

	always_comb begin
		state_nxt = state_r;
		op_nxt    = op_r;
		div_nxt   = div_r;
		dcnt_nxt  = dcnt_r;
		tick_nxt  = tick_r;
		bus_nxt   = bus_r;
		pulse_nxt = pulse_r;
		word_nxt  = word_r;
		addr_nxt  = addr_r;
		fail_nxt  = fail_r;
		done_nxt  = 1'b0;
		wdone_nxt = 1'b0;
		cyc_nxt   = cyc_r + 32'h1;
		fin       = 1'b0;
		case (state_r)
			ST_IDLE: begin
				cyc_nxt = 32'h0;
				if (i_cmd_valid && (is_prog(i_cmd_op) || is_erase(i_cmd_op)
						|| i_cmd_op == OP_BLANK)) begin
					op_nxt    = i_cmd_op;
					div_nxt   = i_flash_clock_divider;
					dcnt_nxt  = i_flash_clock_divider;
					pulse_nxt = 5'h0;
					word_nxt  = 6'h0;
					addr_nxt  = '0;
					fail_nxt  = 1'b0;
					// single word setup in bus cycles
					if (is_prog(i_cmd_op)) begin
						state_nxt = ST_SETUP;
						bus_nxt   = 5'(SWP_BUS - 1);
					end else if (i_cmd_op == OP_BLANK) begin
						state_nxt = ST_SETUP;
						bus_nxt   = 5'(SCAN_SETUP - 1);
					end else if (i_cmd_op == OP_SECT) begin
						state_nxt = ST_OPCLK;
						tick_nxt  = TICK_W'(ERASE_PULSE_TICKS - 1);
					end else begin
						state_nxt = ST_OPCLK;
						tick_nxt  = TICK_W'(MASS_OP_TICKS - 1);
					end
				end
			end
			ST_SETUP: begin
				if (bus_r == 5'h0) begin
					dcnt_nxt = div_r;
					if (op_r == OP_BLANK) begin
						state_nxt = ST_SCAN;
					end else begin
						state_nxt = ST_OPCLK;
						// later burst words use the shorter tick count
						tick_nxt  = (word_r == 6'h0) ? TICK_W'(SWP_TICKS - 1)
							: TICK_W'(BWP_TICKS - 1);
					end
				end else begin
					bus_nxt = bus_r - 5'h1;
				end
			end
			ST_OPCLK: begin
				// one operation period is divider plus one bus cycles
				if (dcnt_r == '0) begin
					dcnt_nxt = div_r;
					if (tick_r == '0) begin
						fin = 1'b1;
					end else begin
						tick_nxt = tick_r - TICK_W'(1);
					end
				end else begin
					dcnt_nxt = dcnt_r - DIV_W'(1);
				end
				if (fin) begin
					// sixteen erase pulses back to back
					if (op_r == OP_SECT && pulse_r != 5'(ERASE_PULSES - 1)) begin
						pulse_nxt = pulse_r + 5'h1;
						tick_nxt  = TICK_W'(ERASE_PULSE_TICKS - 1);
					// next burst word only if one is pending
					end else if (op_r == OP_BURST && i_burst_more
							&& word_r != 6'(BURST_WORDS - 1)) begin
						wdone_nxt = 1'b1;
						word_nxt  = word_r + 6'h1;
						state_nxt = ST_SETUP;
						bus_nxt   = 5'(BWP_BUS - 1);
						cyc_nxt   = 32'h0;
					end else begin
						wdone_nxt = is_prog(op_r);
						done_nxt  = 1'b1;
						state_nxt = ST_IDLE;
					end
				end
			end
			ST_SCAN: begin
				// one word per cycle, stop at first dirty word
				if (!i_word_blank) begin
					fail_nxt  = 1'b1;
					done_nxt  = 1'b1;
					state_nxt = ST_IDLE;
				end else if (addr_r == ADDR_W'(SCAN_WORD_COUNT - 1)) begin
					done_nxt  = 1'b1;
					state_nxt = ST_IDLE;
				end else begin
					addr_nxt = addr_r + ADDR_W'(1);
				end
			end
			default: begin
				state_nxt = ST_IDLE;
			end
		endcase
	end

	always_ff @(posedge i_clk or negedge i_rst_n) begin
		if (!i_rst_n) begin
			state_r <= ST_IDLE;
			op_r    <= 3'h0;
			div_r   <= '0;
			dcnt_r  <= '0;
			tick_r  <= '0;
			bus_r   <= 5'h0;
			pulse_r <= 5'h0;
			word_r  <= 6'h0;
			addr_r  <= '0;
			fail_r  <= 1'b0;
			done_r  <= 1'b0;
			wdone_r <= 1'b0;
			busy_r  <= 1'b0;
			prog_r  <= 1'b0;
			erase_r <= 1'b0;
			cyc_r   <= 32'h0;
		end else begin
			state_r <= state_nxt;
			op_r    <= op_nxt;
			div_r   <= div_nxt;
			dcnt_r  <= dcnt_nxt;
			tick_r  <= tick_nxt;
			bus_r   <= bus_nxt;
			pulse_r <= pulse_nxt;
			word_r  <= word_nxt;
			addr_r  <= addr_nxt;
			fail_r  <= fail_nxt;
			done_r  <= done_nxt;
			wdone_r <= wdone_nxt;
			busy_r  <= (state_nxt != ST_IDLE);
			prog_r  <= (state_nxt == ST_OPCLK) && is_prog(op_nxt);
			erase_r <= (state_nxt == ST_OPCLK) && is_erase(op_nxt);
			cyc_r   <= cyc_nxt;
		end
	end

	assign o_busy        = busy_r;
	assign o_cmd_done    = done_r;
	assign o_word_done   = wdone_r;
	assign o_prog_pulse  = prog_r;
	assign o_erase_pulse = erase_r;
	assign o_scan_addr   = addr_r;
	assign o_scan_fail   = fail_r;

	// ****************************************************************
	// checks
	// ****************************************************************
	default clocking cb @(posedge i_clk); endclocking
	default disable iff (!i_rst_n);

	int per;
	assign per = int'(div_r) + 1;

	sequence s_launch;
		state_r == ST_IDLE && i_cmd_valid;
	endsequence

	sequence s_launch_prog;
		s_launch and (i_cmd_op == OP_PROG);
	endsequence

	no_refuse_a: assert property (
		s_launch and is_erase(i_cmd_op) |=> o_busy && o_erase_pulse)
		else $error("erase command not started");
	prog_setup_a: assert property (
		s_launch_prog |=> (state_r == ST_SETUP && !o_prog_pulse) [*8])
		else $error("program setup too short");
	prog_time_a: assert property (
		fin && is_prog(op_r) && word_r == 6'h0
			|-> cyc_r == 32'(SWP_BUS + SWP_TICKS * per - 1))
		else $error("single word time wrong");
	burst_time_a: assert property (
		fin && op_r == OP_BURST && word_r != 6'h0
			|-> cyc_r == 32'(BWP_BUS + BWP_TICKS * per - 1))
		else $error("burst word time wrong");
	burst_stop_a: assert property (
		fin && op_r == OP_BURST && word_r == 6'(BURST_WORDS - 1)
			|=> o_cmd_done && !o_busy)
		else $error("burst ran past row");
	erase_pulse_a: assert property (
		fin && op_r == OP_SECT |-> cyc_r
			== 32'(ERASE_PULSE_TICKS * per * (int'(pulse_r) + 1) - 1))
		else $error("erase pulse timing wrong");
	mass_time_a: assert property (
		fin && op_r == OP_MASS |-> cyc_r == 32'(MASS_OP_TICKS * per - 1))
		else $error("mass erase time wrong");
	scan_stop_a: assert property (
		state_r == ST_SCAN && !i_word_blank |=> o_cmd_done && o_scan_fail
			&& !o_busy)
		else $error("blank check did not stop");
	scan_time_a: assert property (
		state_r == ST_SCAN && done_nxt
			|-> cyc_r >= 32'(SCAN_SETUP) && cyc_r <= 32'(SCAN_SETUP
			+ SCAN_WORD_COUNT - 1))
		else $error("blank check time out of range");
	done_pulse_a: assert property (
		o_cmd_done |-> !o_busy ##1 !o_cmd_done)
		else $error("done not a single pulse");

endmodule

// ### fpet_flash_model.sv
// flash array model answering blank check reads
module fpet_flash_model
	import fpet_pkg::*;
(
	input  wire logic              i_clk,
	input  wire logic              i_busy,
	input  wire logic [ADDR_W-1:0] i_addr,
	input  wire logic [ADDR_W-1:0] i_dirty,
	output logic                   o_blank
);
	timeunit 1ns;
	timeprecision 1ps;
	logic toggle_r = 1'b0;

	always @(posedge i_clk) begin
		toggle_r <= ~toggle_r;
	end

	assign o_blank = i_busy ? (i_addr < i_dirty) : toggle_r;
endmodule

// ### flash_program_erase_timing_tb.sv
// testbench for the flash timing sequencer
module flash_program_erase_timing_tb
	import fpet_pkg::*;
;
	timeunit 1ns;
	timeprecision 1ps;
	logic i_clk, i_rst_n, i_cmd_valid, i_burst_more, i_word_blank;
	logic [2:0] i_cmd_op;
	logic [DIV_W-1:0] i_flash_clock_divider;
	logic o_busy, o_cmd_done, o_word_done, o_prog_pulse, o_erase_pulse;
	logic o_scan_fail;
	logic [ADDR_W-1:0] o_scan_addr, dirty;
	int err_total, samples_checked, n_b, n_p, n_e, n_w, n_d, p, k, t;
	logic [31:0] rnd = 32'h9357CD9F;

	fpet_seq #(.ERASE_PULSE_TICKS(3), .MASS_OP_TICKS(10),
		.SCAN_WORD_COUNT(8)) dut (
		.i_clk                 (i_clk),
		.i_rst_n               (i_rst_n),
		.i_cmd_valid           (i_cmd_valid),
		.i_cmd_op              (i_cmd_op),
		.i_flash_clock_divider (i_flash_clock_divider),
		.i_burst_more          (i_burst_more),
		.i_word_blank          (i_word_blank),
		.o_busy                (o_busy),
		.o_cmd_done            (o_cmd_done),
		.o_word_done           (o_word_done),
		.o_prog_pulse          (o_prog_pulse),
		.o_erase_pulse         (o_erase_pulse),
		.o_scan_addr           (o_scan_addr),
		.o_scan_fail           (o_scan_fail)
	);
	fpet_flash_model model (.i_clk(i_clk), .i_busy(o_busy),
		.i_addr(o_scan_addr), .i_dirty(dirty), .o_blank(i_word_blank));

	initial begin
		i_clk = 1'b0;
		forever #5 i_clk = ~i_clk;
	end

	function automatic logic [31:0] xs(input logic [31:0] s);
		s = s ^ (s << 13);
		s = s ^ (s >> 17);
		return s ^ (s << 5);
	endfunction

	task automatic finish_test();
		$display("checks %0d mismatches %0d", samples_checked, err_total);
		if (err_total == 0 && samples_checked > 0) $display("Testbench passed");
		else $display("Testbench failed");
		$finish;
	endtask

	task automatic cmp(input logic [31:0] got, input logic [31:0] exp);
		samples_checked++;
		if (got !== exp) begin
			err_total++;
			$display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask

	// launch one command and count what each output other than the scan address and scan fail does
	task automatic run(input logic [2:0] op, input int dv, input int dr,
		input bit poke, input int eb, input int epp, input int eep,
		input int ew, input int ed);
		@(posedge i_clk);
		i_cmd_valid <= 1'b1;
		i_cmd_op <= op;
		i_flash_clock_divider <= dv[DIV_W-1:0];
		dirty <= dr[ADDR_W-1:0];
		{n_b, n_p, n_e, n_w, n_d} = '0;
		for (int i = 0; i < 5000 && n_d == 0 && (ed || i < 20); i++) begin
			@(posedge i_clk);
			i_cmd_valid <= poke && i == 3;
			i_cmd_op <= OP_MASS;
			@(negedge i_clk);
			n_b += (o_busy === 1'b1);
			n_p += (o_prog_pulse === 1'b1);
			n_e += (o_erase_pulse === 1'b1);
			n_w += (o_word_done === 1'b1);
			n_d += (o_cmd_done === 1'b1);
		end
		cmp(n_d, ed);
		if (n_d != ed) finish_test();
		cmp(n_b, eb);
		cmp(n_p, epp);
		cmp(n_e, eep);
		cmp(n_w, ew);
		if (op == OP_BLANK) begin
			cmp(o_scan_fail, dr < 8);
			cmp(o_scan_addr, dr < 8 ? dr : 7);
		end
		$display("test op %0d div %0d done", op, dv);
	endtask

	initial begin
		{i_rst_n, i_cmd_valid, i_burst_more} = '0;
		i_cmd_op = '0;
		i_flash_clock_divider = '0;
		dirty = '0;
		err_total = 0;
		samples_checked = 0;
		repeat (16) @(posedge i_clk);
		i_rst_n <= 1'b1;
		run(OP_PROG, 0, 0, 1, 34, 9, 0, 1, 1);
		run(OP_BURST, 1, 0, 0, 43, 18, 0, 1, 1);
		i_burst_more <= 1'b1;
		run(OP_BURST, 0, 0, 0, 853, 261, 0, 64, 1);
		i_burst_more <= 1'b0;
		run(OP_SECT, 0, 0, 1, 48, 0, 48, 0, 1);
		run(OP_MASS, 2, 0, 0, 30, 0, 30, 0, 1);
		run(OP_BLANK, 0, 0, 0, 11, 0, 0, 0, 1);
		run(OP_BLANK, 3, 8, 0, 18, 0, 0, 0, 1);
		run(3'h6, 0, 0, 0, 0, 0, 0, 0, 0);
		for (int j = 0; j < 12; j++) begin
			rnd = xs(rnd);
			p = rnd[1:0] + 1;
			k = rnd[7:4] % 9;
			case (rnd[9:8])
				2'h0: run(OP_PROG, p - 1, k, 0, 25 + 9 * p, 9 * p, 0, 1, 1);
				2'h1: run(OP_SECT, p - 1, k, 0, 48 * p, 0, 48 * p, 0, 1);
				2'h2: run(OP_MASS, p - 1, k, 0, 10 * p, 0, 10 * p, 0, 1);
				default: begin
					t = k < 8 ? k + 11 : 18;
					run(OP_BLANK, p - 1, k, 0, t, 0, 0, 0, 1);
				end
			endcase
		end
		finish_test();
	end
endmodule
